// File: rtl/sbpc_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the clock configuration unit
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef SBPC_CONSTS_SVH
`define SBPC_CONSTS_SVH
`define SBPC_ADDR_BAUD      8'h3b
`define SBPC_ADDR_TRIM      8'h3c
`define SBPC_ADDR_PLL       8'h3d
`define SBPC_ADDR_ODIV      8'h3e
`define SBPC_ADDR_STAT      8'h50
`define SBPC_RST_BAUD       8'h7a
`define SBPC_RST_TRIM       8'h80
`define SBPC_RST_PLL        8'h00
`define SBPC_RST_ODIV       8'h08
`define SBPC_EXP_MSB        7
`define SBPC_EXP_LSB        5
`define SBPC_MANT_MSB       4
`define SBPC_MANT_LSB       0
`define SBPC_SEL_MSB        7
`define SBPC_SEL_LSB        4
`define SBPC_EN_BIT         3
`define SBPC_PD_BIT         2
`define SBPC_FB_MSB         1
`define SBPC_FB_LSB         0
`define SBPC_ADD_EXP_ZERO   13'h0001
`define SBPC_ADD_EXP_NZ     13'h0021
`define SBPC_FB_MUL_0       5'h17
`define SBPC_FB_MUL_1       5'h1b
`define SBPC_FB_MUL_2       5'h1c
`define SBPC_FB_MUL_3       5'h17
`define SBPC_LAST_DATA_BIT  3'h7
`define SBPC_LFO_BASE       9'h100
`endif

// File: rtl/sbpc_pkg.sv
// Purpose: Types of the clock configuration unit
// Assumes: Nothing
// Notes:   Gray codes along idle, start, data, stop
package sbpc_pkg;
	typedef enum logic [1:0] {
		SBPC_IDLE  = 2'h0,
		SBPC_START = 2'h1,
		SBPC_DATA  = 2'h3,
		SBPC_STOP  = 2'h2
	} sbpc_uart_state_t;
	typedef enum logic [3:0] {
		SBPC_SRC_GPIO = 4'h0,
		SBPC_SRC_PLL  = 4'h1,
		SBPC_SRC_LOW  = 4'h2,
		SBPC_SRC_HIGH = 4'h3,
		SBPC_SRC_XD1  = 4'h4,
		SBPC_SRC_XD2  = 4'h5,
		SBPC_SRC_XD4  = 4'h6,
		SBPC_SRC_XD8  = 4'h7
	} sbpc_clk_src_t;
endpackage

// File: rtl/sbpc_top.sv
// Purpose: Host UART baud generator and link, oscillator trim, PLL and clock pin control
// Assumes: ref_clk is the crystal clock; srst synchronous active high
// Notes:   Analog PLL and oscillator core sit outside; this block steers them
`include "sbpc_consts.svh"
module sbpc_top #(
	parameter int DIV_W = 13
) (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	output logic             tx_ready,
	output logic      [7:0]  rx_data,
	output logic             rx_valid,
	output logic             rx_frame_err,
	input  wire logic        uart_rx_pin,
	output logic             uart_tx_pin,
	output logic             lfo_tick,
	output logic             pll_power_down,
	output logic      [4:0]  pll_feedback_factor,
	output logic      [7:0]  pll_output_divider,
	input  wire logic        pll_analog_clk,
	input  wire logic [3:0]  timer_overflow,
	input  wire logic        gpio_out,
	input  wire logic        gpio_oe_n,
	output logic             clock_output_pin,
	output logic             clock_output_pin_oe_n
);
	import sbpc_pkg::*;

	// Largest divisor is 64 << 6 = 4096
	if (DIV_W < 13) begin : g_chk
		$error("sbpc_top: DIV_W must be at least 13");
	end

	// Registers
	logic [7:0] serial_rate_setting, next_serial_rate_setting;
	logic [7:0] lowfreq_osc_trim, next_lowfreq_osc_trim;
	logic [7:0] pll_ctrl, next_pll_ctrl;
	logic [7:0] next_pll_output_divider;
	logic [7:0] next_reg_rdata;
	logic [4:0] next_pll_feedback_factor;
	logic       tx_busy, rx_busy, baud_pending;

	assign pll_power_down = pll_ctrl[`SBPC_PD_BIT];

	always_comb begin
		next_serial_rate_setting = serial_rate_setting;
		next_lowfreq_osc_trim    = lowfreq_osc_trim;
		next_pll_ctrl            = pll_ctrl;
		next_pll_output_divider  = pll_output_divider;
		next_reg_rdata           = 8'h00;
		if (reg_wr) begin
			case (reg_addr)
				`SBPC_ADDR_BAUD: next_serial_rate_setting = reg_wdata;
				`SBPC_ADDR_TRIM: next_lowfreq_osc_trim    = reg_wdata;
				`SBPC_ADDR_PLL:  next_pll_ctrl            = reg_wdata;
				`SBPC_ADDR_ODIV: next_pll_output_divider  = reg_wdata;
				default:         next_pll_ctrl            = pll_ctrl;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`SBPC_ADDR_BAUD: next_reg_rdata = serial_rate_setting;
				`SBPC_ADDR_TRIM: next_reg_rdata = lowfreq_osc_trim;
				`SBPC_ADDR_PLL:  next_reg_rdata = pll_ctrl;
				`SBPC_ADDR_ODIV: next_reg_rdata = pll_output_divider;
				`SBPC_ADDR_STAT: next_reg_rdata = {5'h00, baud_pending, rx_busy, tx_busy};
				default:         next_reg_rdata = 8'h00;
			endcase
		end
		// Factor handed to the analog loop, which halves the product
		case (next_pll_ctrl[`SBPC_FB_MSB:`SBPC_FB_LSB])
			2'h0:    next_pll_feedback_factor = `SBPC_FB_MUL_0;
			2'h1:    next_pll_feedback_factor = `SBPC_FB_MUL_1;
			2'h2:    next_pll_feedback_factor = `SBPC_FB_MUL_2;
			default: next_pll_feedback_factor = `SBPC_FB_MUL_3;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			serial_rate_setting <= `SBPC_RST_BAUD;
			lowfreq_osc_trim    <= `SBPC_RST_TRIM;
			pll_ctrl            <= `SBPC_RST_PLL;
			pll_output_divider  <= `SBPC_RST_ODIV;
			pll_feedback_factor <= `SBPC_FB_MUL_0;
			reg_rdata           <= 8'h00;
		end else begin
			serial_rate_setting <= next_serial_rate_setting;
			lowfreq_osc_trim    <= next_lowfreq_osc_trim;
			pll_ctrl            <= next_pll_ctrl;
			pll_output_divider  <= next_pll_output_divider;
			pll_feedback_factor <= next_pll_feedback_factor;
			reg_rdata           <= next_reg_rdata;
		end
	end

	// Baud divisor, latched only between characters
	logic [DIV_W-1:0] div_raw, div_base, active_div, next_active_div;
	logic [2:0]       bexp;
	logic [4:0]       bmant;
	sbpc_uart_state_t tx_state, next_tx_state, rx_state, next_rx_state;
	logic             tx_accept, rx_start;

	always_comb begin
		bexp  = serial_rate_setting[`SBPC_EXP_MSB:`SBPC_EXP_LSB];
		bmant = serial_rate_setting[`SBPC_MANT_MSB:`SBPC_MANT_LSB];
		if (bexp == 3'h0) begin
			div_base = DIV_W'({8'h00, bmant} + `SBPC_ADD_EXP_ZERO);
			div_raw  = div_base;
		end else begin
			div_base = DIV_W'({8'h00, bmant} + `SBPC_ADD_EXP_NZ);
			div_raw  = div_base << (bexp - 3'h1);
		end
		next_active_div = active_div;
		// Switching mid-character would stretch or shrink live bits
		if (tx_state == SBPC_IDLE && rx_state == SBPC_IDLE && !tx_accept && !rx_start)
			next_active_div = div_raw;
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			active_div <= DIV_W'(13'h0030);
		else
			active_div <= next_active_div;
	end
	assign baud_pending = (active_div != div_raw);

	// Transmitter
	logic [DIV_W-1:0] tx_cnt, next_tx_cnt;
	logic [2:0]       tx_idx, next_tx_idx;
	logic [7:0]       tx_shift, next_tx_shift;
	logic             next_uart_tx_pin, next_tx_ready;

	assign tx_accept = tx_valid && tx_ready;
	assign tx_busy   = (tx_state != SBPC_IDLE);

	always_comb begin
		next_tx_state    = tx_state;
		next_tx_cnt      = tx_cnt;
		next_tx_idx      = tx_idx;
		next_tx_shift    = tx_shift;
		next_uart_tx_pin = uart_tx_pin;
		if (tx_state != SBPC_IDLE)
			next_tx_cnt = tx_cnt - DIV_W'(1);
		case (tx_state)
			SBPC_IDLE: begin
				next_uart_tx_pin = 1'b1;
				if (tx_accept) begin
					next_tx_shift    = tx_data;
					next_tx_cnt      = active_div - DIV_W'(1);
					next_uart_tx_pin = 1'b0;
					next_tx_state    = SBPC_START;
				end
			end
			SBPC_START: if (tx_cnt == '0) begin
				next_tx_cnt      = active_div - DIV_W'(1);
				next_tx_idx      = 3'h0;
				next_uart_tx_pin = tx_shift[0];
				next_tx_state    = SBPC_DATA;
			end
			SBPC_DATA: if (tx_cnt == '0) begin
				next_tx_cnt = active_div - DIV_W'(1);
				if (tx_idx == `SBPC_LAST_DATA_BIT) begin
					next_uart_tx_pin = 1'b1;
					next_tx_state    = SBPC_STOP;
				end else begin
					next_tx_idx      = tx_idx + 3'h1;
					next_uart_tx_pin = tx_shift[tx_idx + 3'h1];
				end
			end
			SBPC_STOP: if (tx_cnt == '0)
				next_tx_state = SBPC_IDLE;
			default: next_tx_state = SBPC_IDLE;
		endcase
		next_tx_ready = (next_tx_state == SBPC_IDLE);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_state    <= SBPC_IDLE;
			tx_cnt      <= '0;
			tx_idx      <= 3'h0;
			tx_shift    <= 8'h00;
			uart_tx_pin <= 1'b1;
			tx_ready    <= 1'b1;
		end else begin
			tx_state    <= next_tx_state;
			tx_cnt      <= next_tx_cnt;
			tx_idx      <= next_tx_idx;
			tx_shift    <= next_tx_shift;
			uart_tx_pin <= next_uart_tx_pin;
			tx_ready    <= next_tx_ready;
		end
	end

	// Receiver; pin passes two flops first
	logic             rx_meta, rx_sync;
	logic [DIV_W-1:0] rx_cnt, next_rx_cnt;
	logic [2:0]       rx_idx, next_rx_idx;
	logic [7:0]       rx_shift, next_rx_shift, next_rx_data;
	logic             next_rx_valid, next_rx_frame_err;

	assign rx_start = (rx_state == SBPC_IDLE) && !rx_sync;
	assign rx_busy  = (rx_state != SBPC_IDLE);

	always_comb begin
		next_rx_state     = rx_state;
		next_rx_cnt       = rx_cnt;
		next_rx_idx       = rx_idx;
		next_rx_shift     = rx_shift;
		next_rx_data      = rx_data;
		next_rx_valid     = 1'b0;
		next_rx_frame_err = 1'b0;
		if (rx_state != SBPC_IDLE)
			next_rx_cnt = rx_cnt - DIV_W'(1);
		case (rx_state)
			SBPC_IDLE: if (rx_start) begin
				// Half a bit to land mid-bit
				next_rx_cnt   = active_div >> 1;
				next_rx_state = SBPC_START;
			end
			SBPC_START: if (rx_cnt == '0) begin
				next_rx_cnt   = active_div - DIV_W'(1);
				next_rx_idx   = 3'h0;
				// Glitch shorter than half a bit is no start
				next_rx_state = rx_sync ? SBPC_IDLE : SBPC_DATA;
			end
			SBPC_DATA: if (rx_cnt == '0) begin
				next_rx_cnt   = active_div - DIV_W'(1);
				next_rx_shift = {rx_sync, rx_shift[7:1]};
				next_rx_idx   = rx_idx + 3'h1;
				if (rx_idx == `SBPC_LAST_DATA_BIT)
					next_rx_state = SBPC_STOP;
			end
			SBPC_STOP: if (rx_cnt == '0) begin
				next_rx_data      = rx_shift;
				next_rx_valid     = 1'b1;
				next_rx_frame_err = !rx_sync;
				next_rx_state     = SBPC_IDLE;
			end
			default: next_rx_state = SBPC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_meta      <= 1'b1;
			rx_sync      <= 1'b1;
			rx_state     <= SBPC_IDLE;
			rx_cnt       <= '0;
			rx_idx       <= 3'h0;
			rx_shift     <= 8'h00;
			rx_data      <= 8'h00;
			rx_valid     <= 1'b0;
			rx_frame_err <= 1'b0;
		end else begin
			rx_meta      <= uart_rx_pin;
			rx_sync      <= rx_meta;
			rx_state     <= next_rx_state;
			rx_cnt       <= next_rx_cnt;
			rx_idx       <= next_rx_idx;
			rx_shift     <= next_rx_shift;
			rx_data      <= next_rx_data;
			rx_valid     <= next_rx_valid;
			rx_frame_err <= next_rx_frame_err;
		end
	end

	// Oscillator trim: period grows with trim, so frequency falls
	logic [8:0] lfo_cnt, next_lfo_cnt;
	logic       next_lfo_tick;

	always_comb begin
		next_lfo_cnt  = lfo_cnt + 9'h001;
		next_lfo_tick = 1'b0;
		if (lfo_cnt >= `SBPC_LFO_BASE + {1'b0, lowfreq_osc_trim}) begin
			next_lfo_cnt  = 9'h000;
			next_lfo_tick = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lfo_cnt  <= 9'h000;
			lfo_tick <= 1'b0;
		end else begin
			lfo_cnt  <= next_lfo_cnt;
			lfo_tick <= next_lfo_tick;
		end
	end

	// Clock pin
	logic [2:0] xdiv, next_xdiv;
	logic       pll_meta, pll_sync, gpio_meta, gpio_sync, gpio_oe_meta, gpio_oe_sync;
	logic [3:0] tmr_tgl, next_tmr_tgl;
	logic       next_clock_output_pin, next_clock_output_pin_oe_n;

	for (genvar t = 0; t < 4; t++) begin : g_tmr
		assign next_tmr_tgl[t] = tmr_tgl[t] ^ timer_overflow[t];
	end

	always_comb begin
		next_xdiv                  = xdiv + 3'h1;
		next_clock_output_pin_oe_n = 1'b0;
		case (pll_ctrl[`SBPC_SEL_MSB:`SBPC_SEL_LSB])
			SBPC_SRC_GPIO: begin
				next_clock_output_pin      = gpio_sync;
				next_clock_output_pin_oe_n = gpio_oe_sync;
			end
			SBPC_SRC_PLL:  next_clock_output_pin = pll_sync;
			SBPC_SRC_LOW:  next_clock_output_pin = 1'b0;
			SBPC_SRC_HIGH: next_clock_output_pin = 1'b1;
			// A flop cannot show the full clock; fastest is half rate
			SBPC_SRC_XD1:  next_clock_output_pin = next_xdiv[0];
			SBPC_SRC_XD2:  next_clock_output_pin = next_xdiv[0];
			SBPC_SRC_XD4:  next_clock_output_pin = next_xdiv[1];
			SBPC_SRC_XD8:  next_clock_output_pin = next_xdiv[2];
			4'h8:          next_clock_output_pin = next_tmr_tgl[0];
			4'h9:          next_clock_output_pin = next_tmr_tgl[1];
			4'ha:          next_clock_output_pin = next_tmr_tgl[2];
			4'hb:          next_clock_output_pin = next_tmr_tgl[3];
			default:       next_clock_output_pin = 1'b0;
		endcase
		if (!pll_ctrl[`SBPC_EN_BIT]) begin
			next_clock_output_pin      = 1'b0;
			next_clock_output_pin_oe_n = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			xdiv                  <= 3'h0;
			tmr_tgl               <= 4'h0;
			pll_meta              <= 1'b0;
			pll_sync              <= 1'b0;
			gpio_meta             <= 1'b0;
			gpio_sync             <= 1'b0;
			gpio_oe_meta          <= 1'b1;
			gpio_oe_sync          <= 1'b1;
			clock_output_pin      <= 1'b0;
			clock_output_pin_oe_n <= 1'b1;
		end else begin
			xdiv                  <= next_xdiv;
			tmr_tgl               <= next_tmr_tgl;
			pll_meta              <= pll_analog_clk;
			pll_sync              <= pll_meta;
			gpio_meta             <= gpio_out;
			gpio_sync             <= gpio_meta;
			gpio_oe_meta          <= gpio_oe_n;
			gpio_oe_sync          <= gpio_oe_meta;
			clock_output_pin      <= next_clock_output_pin;
			clock_output_pin_oe_n <= next_clock_output_pin_oe_n;
		end
	end
endmodule

// File: sim/sbpc_top_checker.sv
// Purpose: Port assertions for the clock configuration unit
// Assumes: One clock domain; no baud write at a start edge
// Notes:   Shadows of baud and trim follow host writes
module sbpc_top_checker (
	input wire logic       ref_clk,
	input wire logic       srst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic       rx_valid,
	input wire logic       rx_frame_err,
	input wire logic       uart_tx_pin,
	input wire logic       lfo_tick,
	input wire logic       pll_power_down,
	input wire logic [4:0] pll_feedback_factor,
	input wire logic [7:0] pll_output_divider,
	input wire logic       clock_output_pin,
	input wire logic       clock_output_pin_oe_n
);
	logic [7:0]  baud;
	logic [7:0]  trim;
	logic [15:0] d_cur;
	logic [15:0] busy;
	logic [9:0]  lfo_cnt;
	logic        lfo_ok;
	function automatic logic [15:0] div_of(input logic [7:0] b);
		if (b[7:5] == 3'h0)
			return 16'(b[4:0]) + 16'h0001;
		return (16'(b[4:0]) + 16'h0021) << (b[7:5] - 3'h1);
	endfunction
	function automatic logic [4:0] fb_of(input logic [1:0] c);
		return c == 2'h1 ? 5'h1b : (c == 2'h2 ? 5'h1c : 5'h17);
	endfunction
	// Divisor is latched at the start edge, so a mid-character write cannot move it
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			baud <= 8'h7a;
			trim <= 8'h80;
			d_cur <= 16'h00ec;
			busy <= 16'h0000;
			lfo_cnt <= 10'h000;
			lfo_ok <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == 8'h3b)
				baud <= reg_wdata;
			if (tx_valid && tx_ready)
				d_cur <= div_of(baud);
			busy <= tx_ready ? 16'h0000 : busy + 16'h0001;
			lfo_cnt <= lfo_tick ? 10'h001 : lfo_cnt + 10'h001;
			if (reg_wr && reg_addr == 8'h3c) begin
				trim <= reg_wdata;
				lfo_ok <= 1'b0;
			end else if (lfo_tick)
				lfo_ok <= 1'b1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	a_baud_readback: assert property (reg_rd && reg_addr == 8'h3b |=> reg_rdata == $past(baud))
		else $error("baud readback differs");
	a_char_length: assert property ($rose(tx_ready) |-> busy == d_cur * 16'h000a)
		else $error("character length wrong");
	a_tx_start_low: assert property (tx_valid && tx_ready |=> !uart_tx_pin && !tx_ready)
		else $error("start bit missing");
	a_tx_idle_high: assert property (tx_ready |-> uart_tx_pin)
		else $error("idle line not high");
	a_rx_err_pair: assert property (rx_frame_err |-> rx_valid)
		else $error("frame error without byte");
	a_fb_factor: assert property (reg_wr && reg_addr == 8'h3d ##1 !(reg_wr && reg_addr == 8'h3d) |=>
		pll_feedback_factor == fb_of($past(reg_wdata[1:0], 2)) && pll_power_down == $past(reg_wdata[2], 2))
		else $error("feedback factor or power down wrong");
	a_out_divider: assert property (reg_wr && reg_addr == 8'h3e ##1 !(reg_wr && reg_addr == 8'h3e) |=>
		pll_output_divider == $past(reg_wdata, 2))
		else $error("output divider wrong");
	a_pin_gated: assert property (reg_wr && reg_addr == 8'h3d && !reg_wdata[3] ##1
		!(reg_wr && reg_addr == 8'h3d) |=> clock_output_pin_oe_n && !clock_output_pin)
		else $error("clock pin not released");
	a_lfo_period: assert property (lfo_tick && lfo_ok |-> lfo_cnt == 10'h101 + 10'(trim))
		else $error("oscillator period wrong");
endmodule
bind sbpc_top sbpc_top_checker u_sbpc_chk (
	.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame_err(rx_frame_err),
	.uart_tx_pin(uart_tx_pin), .lfo_tick(lfo_tick), .pll_power_down(pll_power_down),
	.pll_feedback_factor(pll_feedback_factor), .pll_output_divider(pll_output_divider),
	.clock_output_pin(clock_output_pin), .clock_output_pin_oe_n(clock_output_pin_oe_n)
);

// File: sim/sbpc_host_model.sv
// Purpose: Host controller end of the serial link
// Assumes: Tasks are entered just after a rising edge
// Notes:   Bit time is given per call in ref_clk cycles
module sbpc_host_model (
	input  wire logic ref_clk,
	input  wire logic dev_tx,
	output logic      dev_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	initial dev_rx = 1'b1;
	// Low stop is cut short so the tail is not taken for a new start
	task automatic send(input logic [7:0] b, input int d, input logic stp);
		dev_rx <= 1'b0;
		repeat (d) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			dev_rx <= b[i];
			repeat (d) @(posedge ref_clk);
		end
		dev_rx <= stp;
		repeat (stp ? d : d / 2 + 4) @(posedge ref_clk);
		dev_rx <= 1'b1;
	endtask
	task automatic recv(input int d, output logic [7:0] b, output logic stp);
		int n;
		n = 0;
		while (dev_tx !== 1'b0 && n < 4000) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (d / 2) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (d) @(posedge ref_clk);
			b[i] = dev_tx;
		end
		repeat (d) @(posedge ref_clk);
		stp = dev_tx;
		// No start seen: hand back unknowns so the bench compare fails
		if (n >= 4000) begin
			b   = 'x;
			stp = 1'bx;
		end
	endtask
endmodule

// File: sim/sbpc_top_bench.sv
// Purpose: Self-checking bench of the clock configuration unit
// Assumes: 50 MHz ref_clk; host model on the serial pins
// Notes:   Rows hold baud settings with a byte each way
module sbpc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] baud; logic [7:0] tb; logic [7:0] rb;} sbpc_row_t;
	logic ref_clk = 1'b0, srst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, txv = 1'b0, s, p;
	logic [7:0] addr = 8'h00, wd = 8'h00, txd = 8'h00, rdata, rxd, od, b;
	logic [3:0] tmr = 4'h0;
	logic gpo = 1'b1, gpoe = 1'b0, pllc = 1'b1;
	logic [4:0] fb;
	logic txr, rxv, rxe, rxp, txp, tick, pd, cp, cpoe;
	int err_count = 0, comparisons = 0, cyc = 0, d, n;
	logic [4:0] fbx[4] = '{5'h17, 5'h1b, 5'h1c, 5'h17};
	logic [9:0] pins[6] = '{10'h022, 10'h062, 10'h0a0, 10'h0e2, 10'h0c1, 10'h320};
	sbpc_row_t rows[5] = '{'{8'h15, 8'h01, 8'h80}, '{8'h1c, 8'ha5, 8'h5a},
		'{8'h3a, 8'hff, 8'h00}, '{8'h5a, 8'h3c, 8'hc3}, '{8'h7a, 8'h96, 8'h69}};
	sbpc_top DUT (
		.ref_clk(ref_clk), .srst(srst), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr_s),
		.reg_rd(rd_s), .reg_rdata(rdata), .tx_data(txd), .tx_valid(txv), .tx_ready(txr),
		.rx_data(rxd), .rx_valid(rxv), .rx_frame_err(rxe), .uart_rx_pin(rxp),
		.uart_tx_pin(txp), .lfo_tick(tick), .pll_power_down(pd), .pll_feedback_factor(fb),
		.pll_output_divider(od), .pll_analog_clk(pllc), .timer_overflow(tmr),
		.gpio_out(gpo), .gpio_oe_n(gpoe), .clock_output_pin(cp), .clock_output_pin_oe_n(cpoe)
	);
	sbpc_host_model host (.ref_clk(ref_clk), .dev_tx(txp), .dev_rx(rxp));
	always #10 ref_clk = ~ref_clk;
	function automatic int dv(input logic [7:0] r);
		return r[7:5] == 3'h0 ? r[4:0] + 6'h01 : (r[4:0] + 6'h21) << (r[7:5] - 3'h1);
	endfunction
	task automatic finish_test();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		wd <= v;
		wr_s <= 1'b1;
		@(posedge ref_clk);
		wr_s <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge ref_clk);
		rd_s <= 1'b0;
		@(posedge ref_clk);
		chk(nm, 16'(e), 16'(rdata));
	endtask
	// Waits one idle edge first so a pending baud value is in place
	task automatic tx(input logic [7:0] v);
		do @(posedge ref_clk); while (txr !== 1'b1);
		@(posedge ref_clk);
		txd <= v;
		txv <= 1'b1;
		do @(posedge ref_clk); while (txr !== 1'b1);
		txv <= 1'b0;
	endtask
	task automatic rx_get(output logic [7:0] v, output logic e);
		int k;
		k = 0;
		while (rxv !== 1'b1 && k < 6000) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 6000)
			err_count++;
		v = rxd;
		e = rxe;
	endtask
	task automatic lfo(output int c);
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (tick !== 1'b1 && c < 1000);
		if (c >= 1000)
			err_count++;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			wr(8'h3b, rows[i].baud);
			rdc("baud", 8'h3b, rows[i].baud);
			d = dv(rows[i].baud);
			tx(rows[i].tb);
			host.recv(d, b, s);
			chk("tx byte", 16'(rows[i].tb), 16'(b));
			chk("tx stop", 16'h0001, 16'(s));
			fork
				host.send(rows[i].rb, d, 1'b1);
				rx_get(b, s);
			join
			chk("rx byte", 16'(rows[i].rb), 16'(b));
			chk("rx error", 16'h0000, 16'(s));
		end
		tx(8'h5a);
		fork
			host.recv(236, b, s);
			begin
				wr(8'h3b, 8'h15);
				rdc("status busy", 8'h50, 8'h05);
			end
		join
		chk("old rate byte", 16'h005a, 16'(b));
		tx(8'hc6);
		host.recv(22, b, s);
		chk("new rate byte", 16'h00c6, 16'(b));
		fork
			host.send(8'h0f, 22, 1'b0);
			rx_get(b, s);
		join
		chk("frame error", 16'h0001, 16'(s));
		repeat (40) @(posedge ref_clk);
		srst <= 1'b1;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		rdc("baud reset", 8'h3b, 8'h7a);
		rdc("trim reset", 8'h3c, 8'h80);
		rdc("pll reset", 8'h3d, 8'h00);
		rdc("odiv reset", 8'h3e, 8'h08);
		rdc("unmapped", 8'h3f, 8'h00);
		rdc("status idle", 8'h50, 8'h00);
		chk("fb reset", 16'h0017, 16'(fb));
		for (int c = 0; c < 4; c++) begin
			wr(8'h3d, 8'(c) | 8'h04);
			repeat (3) @(posedge ref_clk);
			chk("fb factor", 16'(fbx[c]), 16'(fb));
			chk("power down", 16'h0001, 16'(pd));
		end
		wr(8'h3e, 8'hff);
		rdc("odiv", 8'h3e, 8'hff);
		chk("odiv port", 16'h00ff, 16'(od));
		foreach (pins[i]) begin
			wr(8'h3d, pins[i][9:2]);
			repeat (5) @(posedge ref_clk);
			chk("pin", 16'(pins[i][1]), 16'(cp));
			chk("pin oe_n", 16'(pins[i][0]), 16'(cpoe));
		end
		// Flip the pin sources so a stuck pin cannot pass
		gpo  <= 1'b0;
		gpoe <= 1'b1;
		pllc <= 1'b0;
		wr(8'h3d, 8'h08);
		repeat (5) @(posedge ref_clk);
		chk("pin io", 16'h0000, 16'(cp));
		chk("pin io oe_n", 16'h0001, 16'(cpoe));
		wr(8'h3d, 8'h18);
		repeat (5) @(posedge ref_clk);
		chk("pin pll", 16'h0000, 16'(cp));
		for (int k = 4; k < 8; k++) begin
			wr(8'h3d, 8'(k << 4) | 8'h08);
			repeat (4) @(posedge ref_clk);
			n = 0;
			p = cp;
			repeat (64) begin
				@(posedge ref_clk);
				n += int'(cp !== p);
				p = cp;
			end
			chk("xtal toggles", 16'(k == 4 ? 64 : 128 >> (k - 4)), 16'(n));
		end
		for (int t = 0; t < 4; t++) begin
			wr(8'h3d, 8'(t + 8) << 4 | 8'h08);
			repeat (3) @(posedge ref_clk);
			p = cp;
			tmr[t] <= 1'b1;
			@(posedge ref_clk);
			tmr[t] <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk("timer toggle", 16'(!p), 16'(cp));
		end
		for (int t = 0; t < 2; t++) begin
			wr(8'h3c, t ? 8'hff : 8'h00);
			lfo(n);
			lfo(n);
			chk("lfo period", t ? 16'h0200 : 16'h0101, 16'(n));
		end
		finish_test();
	end
endmodule
